// ==== slo_ctrl.sv ====
// indicator-one control with avalon-mm register slave
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE_01: bits 7:4 of the blink control register pick the mode-2 blink rate, reset code 7.
// RULE_02: code 7 blinks once every two seconds with about sixteen percent off time.
// RULE_03: bit 15 of the control register puts the indicator in force mode.
// RULE_04: in force mode bits 14:13 give 11 blink mode 2, 10 blink mode 1, 01 on, 00 off.
// RULE_05: bit 12 lets traffic blink the indicator always, or only when it was on.
// RULE_06: bit 11 lights the indicator on a full duplex link when nothing blinks.
// RULE_07: bit 10 lights the indicator on a half duplex link when nothing blinks.
// RULE_08: bit 9 blinks at mode 2 on transmit traffic when force or a duplex or speed on-condition (bits 11, 10, 5, 4) is enabled.
// RULE_09: bit 8 blinks at mode 2 on receive traffic under the same qualification.
// RULE_10: bit 7 lights the indicator on transmit traffic for at least ten ms.
// RULE_11: bit 6 lights the indicator on receive traffic for at least ten ms.
// RULE_12: bit 5 lights the indicator on a 100 Mbps link when nothing blinks.
// RULE_13: bit 4 lights the indicator on a 10 Mbps link when nothing blinks, default set.
// RULE_14: bit 3 blinks the indicator on collisions while the link is up.
// RULE_15: bit 2 blinks the indicator while the link is up at 100 Mbps.
// RULE_16: bit 1 blinks the indicator while the link is up at 10 Mbps.
// RULE_17: blink beats on, force beats everything, and with nothing active it is off.
module slo_ctrl #(
  parameter int unsigned MS_TICK = slo_pkg::MS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // avalon-mm slave, byte addressed
  input  wire logic [17:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output var  logic [31:0]          avs_readdata,
  output var  logic                 avs_waitrequest,
  // link status from the phy core
  input  wire slo_pkg::slo_status_t phy_status,
  // indicator drive, high is lit
  output var  logic                 indicator_one
);
  import slo_pkg::*;

  localparam int unsigned TW = $clog2(MS_TICK + 1);

  // ***********************************************************
  // register bus
  // ***********************************************************
  logic [15:0] comcon_q;
  logic [15:0] blcon_q;
  logic [15:0] con1_q;
  logic [15:0] rd_mux;
  logic [15:0] reg_idx;
  logic [1:0]  hold_live;
  logic        ind_q;

  assign reg_idx = avs_address[17:2];

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [15:0] msk);
    logic [15:0] nv;
    nv = old;
    if (be[0]) nv[7:0] = wd[7:0];
    if (be[1]) nv[15:8] = wd[15:8];
    merge16 = (nv & msk) | (old & ~msk);
  endfunction

  always_comb begin
    case (reg_idx)
      REG_COMCON_IDX: rd_mux = comcon_q;
      REG_BLCON_IDX:  rd_mux = blcon_q;
      REG_CON1_IDX:   rd_mux = con1_q;
      REG_STAT_IDX:   rd_mux = {8'h00, 2'b00, hold_live,
                                phy_status.full_duplex,
                                phy_status.speed_100,
                                phy_status.link_up, ind_q};
      default:        rd_mux = 16'h0000;
    endcase
  end

  // one wait cycle for every access, then the answer for one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= {16'h0000, rd_mux};
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // writes land on the edge where waitrequest is seen low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      comcon_q <= COMCON_RESET;
      blcon_q  <= BLCON_RESET; // RULE_01
      con1_q   <= CON1_RESET;
    end else if (avs_write && !avs_waitrequest) begin
      case (reg_idx)
        REG_COMCON_IDX: comcon_q <= merge16(comcon_q, avs_writedata,
                                            avs_byteenable, COMCON_WMASK);
        REG_BLCON_IDX:  blcon_q  <= merge16(blcon_q, avs_writedata,
                                            avs_byteenable, BLCON_WMASK);
        REG_CON1_IDX:   con1_q   <= merge16(con1_q, avs_writedata,
                                            avs_byteenable, CON1_WMASK);
        default: ;
      endcase
    end
  end

  // ***********************************************************
  // millisecond tick
  // ***********************************************************
  logic [TW-1:0] tick_cnt_q;
  logic          ms_tick_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_cnt_q <= '0;
      ms_tick_q  <= 1'b0;
    end else begin
      ms_tick_q <= (tick_cnt_q == TW'(MS_TICK - 1));
      if (tick_cnt_q == TW'(MS_TICK - 1)) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end

  // ***********************************************************
  // blink generators, index 0 is mode 1 and index 1 is mode 2
  // ***********************************************************
  logic [3:0]  fsel [2];
  logic [13:0] bl_cnt_q [2];
  logic [1:0]  bl_lit;
  slo_blink_t  shape [2];

  assign fsel[0] = blcon_q[BL_FSEL1_LSB +: 4];
  assign fsel[1] = blcon_q[BL_FSEL2_LSB +: 4]; // RULE_01

  for (genvar g = 0; g < 2; g++) begin : g_blink
    assign shape[g] = slo_blink_shape(fsel[g]); // RULE_02
    // off time sits at the end of each period; duty inversion swaps it
    assign bl_lit[g] = (bl_cnt_q[g] < (shape[g].period_ms -
                        shape[g].off_ms)) ^ comcon_q[COM_DUTY_INV];
    always_ff @(posedge core_clk) begin
      if (srst) begin
        bl_cnt_q[g] <= 14'd0;
      end else if (ms_tick_q) begin
        // a rate change mid-period may leave the count past the end
        if (bl_cnt_q[g] >= shape[g].period_ms - 14'd1) begin
          bl_cnt_q[g] <= 14'd0;
        end else begin
          bl_cnt_q[g] <= bl_cnt_q[g] + 14'd1;
        end
      end
    end
  end

  // ***********************************************************
  // activity stretch, index 0 transmit and index 1 receive
  // ***********************************************************
  logic [1:0] act_in;
  logic [3:0] hold_q [2];

  assign act_in = {phy_status.rx_active, phy_status.tx_active};

  for (genvar a = 0; a < 2; a++) begin : g_hold
    assign hold_live[a] = (hold_q[a] != 4'd0);
    always_ff @(posedge core_clk) begin
      if (srst) begin
        hold_q[a] <= 4'd0;
      end else if (act_in[a]) begin
        hold_q[a] <= ACT_HOLD_TICKS; // RULE_10 RULE_11
      end else if (ms_tick_q && hold_live[a]) begin
        hold_q[a] <= hold_q[a] - 4'd1;
      end
    end
  end

  // ***********************************************************
  // indicator decision
  // ***********************************************************
  logic      link;
  logic      fast;
  logic      slow;
  logic      stat_blink;
  logic      on_cond;
  logic      act_qual;
  logic      act_seen;
  logic      act_blink;
  logic      over_en;
  logic      lit_d;
  slo_mode_t mode_d;

  assign link = phy_status.link_up;
  assign fast = link && phy_status.speed_100;
  assign slow = link && !phy_status.speed_100;
  assign over_en = con1_q[C1_OVR_EN];

  assign stat_blink = (con1_q[C1_COL_BLK] && link &&
                       phy_status.collision) ||          // RULE_14
                      (con1_q[C1_FAST_BLK] && fast) ||   // RULE_15
                      (con1_q[C1_SLOW_BLK] && slow);     // RULE_16

  assign on_cond =
    (con1_q[C1_FDX_ON] && link && phy_status.full_duplex) ||  // RULE_06
    (con1_q[C1_HDX_ON] && link && !phy_status.full_duplex) || // RULE_07
    (con1_q[C1_FAST_ON] && fast) ||                           // RULE_12
    (con1_q[C1_SLOW_ON] && slow) ||                           // RULE_13
    (con1_q[C1_TX_ON] && link && hold_live[0]) ||             // RULE_10
    (con1_q[C1_RX_ON] && link && hold_live[1]);               // RULE_11

  assign act_qual = over_en || con1_q[C1_FDX_ON] || con1_q[C1_HDX_ON] ||
                    con1_q[C1_FAST_ON] || con1_q[C1_SLOW_ON];
  assign act_seen = link && act_qual &&
                    ((con1_q[C1_TX_BLK] && hold_live[0]) ||   // RULE_08
                     (con1_q[C1_RX_BLK] && hold_live[1]));    // RULE_09
  // policy clear: traffic only blinks an indicator that is lit
  assign act_blink = act_seen &&
                     (con1_q[C1_ACT_POLICY] || on_cond);      // RULE_05

  always_comb begin
    if (over_en) begin // RULE_03
      case (con1_q[C1_OVR_ST_LSB +: 2]) // RULE_04
        2'b11:   mode_d = SLO_BLINK2;
        2'b10:   mode_d = SLO_BLINK1;
        2'b01:   mode_d = SLO_ON;
        default: mode_d = SLO_OFF;
      endcase
    end else if (stat_blink || act_blink) begin // RULE_17
      mode_d = SLO_BLINK2;
    end else if (on_cond) begin
      mode_d = SLO_ON;
    end else begin
      mode_d = SLO_OFF;
    end
  end

  always_comb begin
    case (mode_d)
      SLO_ON:     lit_d = 1'b1;
      SLO_BLINK1: lit_d = bl_lit[0];
      SLO_BLINK2: lit_d = bl_lit[1];
      default:    lit_d = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ind_q <= 1'b0;
    end else begin
      ind_q <= lit_d;
    end
  end

  assign indicator_one = ind_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_force_held_off: assert property ( // RULE_04
    (over_en && con1_q[14:13] == 2'b00)[*2] |-> !indicator_one)
    else $error("forced off indicator is lit");
  a_force_held_on: assert property ( // RULE_03
    (over_en && con1_q[14:13] == 2'b01)[*2] |-> indicator_one)
    else $error("forced on indicator is dark");
  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait");
  a_act_hold_load: assert property ( // RULE_10
    phy_status.tx_active |=> hold_q[0] == 4'd11)
    else $error("transmit hold not loaded");
  a_idle_link_off: assert property ( // RULE_17
    (!over_en && !link)[*2] |-> !indicator_one)
    else $error("indicator lit without link or force");
  a_freq_reset: assert property ( // RULE_01
    $fell(srst) |-> blcon_q[7:4] == 4'h7)
    else $error("mode-2 rate code not 7 after reset");
  a_blink_count: assert property ( // RULE_02
    fsel[1] == 4'h7 && $stable(fsel[1]) |-> bl_cnt_q[1] < 14'd2000)
    else $error("mode-2 count passes its period");
  a_slow_link_on: assert property ( // RULE_13
    (!over_en && slow && con1_q[4] && mode_d != SLO_BLINK2)[*2]
    |-> indicator_one)
    else $error("slow link not shown");
  a_collision_blink: assert property ( // RULE_14
    !over_en && link && phy_status.collision && con1_q[3]
    |-> mode_d == SLO_BLINK2)
    else $error("collision does not blink");

  c_force_blink: cover property (over_en && mode_d == SLO_BLINK1);
  c_act_blink: cover property (act_blink && !con1_q[12]);
  c_reg_write: cover property (avs_write && !avs_waitrequest);
  c_blink_edge: cover property (mode_d == SLO_BLINK2 && $fell(bl_lit[1]));

endmodule

`default_nettype wire

// ==== slo_pkg.sv ====
// constants, types and blink table for the indicator-one controller
package slo_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned MS_TICK_NS     = 1000000;
  localparam int unsigned MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned ACT_HOLD_MS    = 10;
  // one extra tick since the first tick may come at once
  localparam logic [3:0]  ACT_HOLD_TICKS = 4'(ACT_HOLD_MS + 1);

  // ***********************************************************
  // register indexes, byte address is four times the index
  // ***********************************************************
  localparam logic [15:0] REG_COMCON_IDX = 16'h40c1;
  localparam logic [15:0] REG_BLCON_IDX  = 16'h40c2;
  localparam logic [15:0] REG_CON1_IDX   = 16'h40c3;
  localparam logic [15:0] REG_STAT_IDX   = 16'h40c4;

  localparam logic [15:0] COMCON_RESET = 16'h0000;
  localparam logic [15:0] COMCON_WMASK = 16'h0200;
  localparam logic [15:0] BLCON_RESET  = 16'hec70;
  localparam logic [15:0] BLCON_WMASK  = 16'hfff0;
  localparam logic [15:0] CON1_RESET   = 16'h0310;
  localparam logic [15:0] CON1_WMASK   = 16'hfffe;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int unsigned COM_DUTY_INV   = 9;
  localparam int unsigned BL_FSEL1_LSB   = 8;
  localparam int unsigned BL_FSEL2_LSB   = 4;
  localparam int unsigned C1_OVR_EN      = 15;
  localparam int unsigned C1_OVR_ST_LSB  = 13;
  localparam int unsigned C1_ACT_POLICY  = 12;
  localparam int unsigned C1_FDX_ON      = 11;
  localparam int unsigned C1_HDX_ON      = 10;
  localparam int unsigned C1_TX_BLK      = 9;
  localparam int unsigned C1_RX_BLK      = 8;
  localparam int unsigned C1_TX_ON       = 7;
  localparam int unsigned C1_RX_ON       = 6;
  localparam int unsigned C1_FAST_ON     = 5;
  localparam int unsigned C1_SLOW_ON     = 4;
  localparam int unsigned C1_COL_BLK     = 3;
  localparam int unsigned C1_FAST_BLK    = 2;
  localparam int unsigned C1_SLOW_BLK    = 1;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic collision;
  } slo_status_t;

  typedef enum logic [1:0] {
    SLO_OFF, SLO_ON, SLO_BLINK1, SLO_BLINK2
  } slo_mode_t;

  typedef struct packed {
    logic [13:0] period_ms;
    logic [13:0] off_ms;
  } slo_blink_t;

  // period and off time per frequency code, in ms
  function automatic slo_blink_t slo_blink_shape(input logic [3:0] code);
    case (code)
      4'h0:    slo_blink_shape = '{14'd10000, 14'd600};
      4'h1:    slo_blink_shape = '{14'd9400, 14'd658};
      4'h2:    slo_blink_shape = '{14'd8000, 14'd640};
      4'h3:    slo_blink_shape = '{14'd7400, 14'd666};
      4'h4:    slo_blink_shape = '{14'd6000, 14'd660};
      4'h5:    slo_blink_shape = '{14'd4000, 14'd320};
      4'h6:    slo_blink_shape = '{14'd3000, 14'd330};
      4'h7:    slo_blink_shape = '{14'd2000, 14'd320};
      4'h8:    slo_blink_shape = '{14'd1000, 14'd160};
      4'h9:    slo_blink_shape = '{14'd1000, 14'd160};
      4'ha:    slo_blink_shape = '{14'd500, 14'd250};
      4'hb:    slo_blink_shape = '{14'd333, 14'd166};
      4'hc:    slo_blink_shape = '{14'd250, 14'd125};
      4'hd:    slo_blink_shape = '{14'd167, 14'd83};
      4'he:    slo_blink_shape = '{14'd125, 14'd62};
      default: slo_blink_shape = '{14'd100, 14'd50};
    endcase
  endfunction

endpackage

// ==== tb_top.sv ====
// self-checking testbench for the indicator-one controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import slo_pkg::*;
  // ***********************************************************
  // signals and design
  // ***********************************************************
  // a short ms tick of two cycles keeps every blink period within 20000 cycles
  localparam int unsigned TICK = 2;
  logic        core_clk;
  logic        srst;
  logic [17:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  slo_status_t phy_status;
  logic        indicator_one;
  int          n_fail;
  int          compares;
  logic [31:0] rd;

  slo_ctrl #(.MS_TICK(TICK)) u_slo_ctrl (
    .core_clk        (core_clk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .phy_status      (phy_status),
    .indicator_one   (indicator_one)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; request held until waitrequest low
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [15:0] wd);
    int k;
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {16'h0000, wd};
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge core_clk);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // set control and status, then count lit cycles over a window
  task automatic run_case(input logic [15:0] con, input logic [5:0] st,
                          input int n, input int exp);
    int lit;
    int d;
    bus(1'b1, REG_CON1_IDX, con);
    phy_status <= st;
    cycles(4);
    lit = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (indicator_one === 1'b1) lit++;
    end
    @(posedge core_clk);
    d = lit - exp;
    // blink phase is free running, so allow a few cycles of slack
    check(32'(d <= 4 && d >= -4), 32'h1);
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_regs();
    bus(1'b0, REG_CON1_IDX, 16'h0000);
    check(rd, 32'h0000_0310);
    bus(1'b0, REG_BLCON_IDX, 16'h0000);
    check(32'(rd[7:4]), 32'h7);
    bus(1'b1, REG_CON1_IDX, 16'hffff);
    bus(1'b0, REG_CON1_IDX, 16'h0000);
    check(rd, 32'h0000_fffe);
    // upper lane only: the low byte must keep its value
    avs_byteenable <= 4'h2;
    bus(1'b1, REG_CON1_IDX, 16'h0000);
    avs_byteenable <= 4'h3;
    bus(1'b0, REG_CON1_IDX, 16'h0000);
    check(rd, 32'h0000_00fe);
    bus(1'b0, 16'h40d0, 16'h0000);
    check(rd, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_default();
    run_case(16'h0310, 6'b100000, 200, 200);
    // status view: lit indicator and link up, 10 Mbps half duplex
    bus(1'b0, REG_STAT_IDX, 16'h0000);
    check(rd, 32'h0000_0003);
    run_case(16'h0310, 6'b000000, 200, 0);
    run_case(16'h0310, 6'b110000, 200, 0);
    $display("test default done");
  endtask

  task automatic t_on_conds();
    run_case(16'h0800, 6'b101000, 200, 200);
    run_case(16'h0800, 6'b100000, 200, 0);
    run_case(16'h0400, 6'b100000, 200, 200);
    run_case(16'h0400, 6'b101000, 200, 0);
    run_case(16'h0020, 6'b110000, 200, 200);
    $display("test on done");
  endtask

  task automatic t_force();
    run_case(16'h8310, 6'b100000, 200, 0);
    run_case(16'ha000, 6'b000000, 200, 200);
    run_case(16'he000, 6'b000000, 4000, 3360);
    run_case(16'hc000, 6'b000000, 1000, 500);
    run_case(16'h0000, 6'b111111, 200, 0);
    $display("test force done");
  endtask

  task automatic t_blink();
    run_case(16'h0008, 6'b100001, 4000, 3360);
    run_case(16'h0004, 6'b110000, 4000, 3360);
    run_case(16'h0002, 6'b100000, 4000, 3360);
    run_case(16'h000e, 6'b010001, 200, 0);
    run_case(16'h0024, 6'b110000, 4000, 3360);
    $display("test blink done");
  endtask

  task automatic t_activity();
    run_case(16'h0320, 6'b100100, 200, 0);
    run_case(16'h1320, 6'b100100, 4000, 3360);
    run_case(16'h0310, 6'b100100, 4000, 3360);
    run_case(16'h0110, 6'b100010, 4000, 3360);
    run_case(16'h1200, 6'b100100, 200, 0);
    $display("test activity done");
  endtask

  task automatic t_rate();
    bus(1'b1, REG_BLCON_IDX, 16'heca0);
    run_case(16'he000, 6'b000000, 1000, 500);
    bus(1'b1, REG_BLCON_IDX, 16'hec70);
    // duty inversion leaves only the 320 ms off share lit
    bus(1'b1, REG_COMCON_IDX, 16'h0200);
    run_case(16'he000, 6'b000000, 4000, 640);
    bus(1'b1, REG_COMCON_IDX, 16'h0000);
    $display("test rate done");
  endtask

  // one-cycle traffic pulse must stretch to 10 ms, 20 cycles here
  task automatic t_hold(input logic [15:0] con, input logic [5:0] pulse);
    run_case(con, 6'b100000, 20, 0);
    phy_status <= pulse;
    cycles(1);
    phy_status <= 6'b100000;
    cycles(20);
    @(negedge core_clk);
    check(32'(indicator_one), 32'h1);
    cycles(23);
    @(negedge core_clk);
    check(32'(indicator_one), 32'h0);
    @(posedge core_clk);
    $display("test hold done");
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    n_fail         = 0;
    compares       = 0;
    srst           = 1'b1;
    avs_address    = 18'h00000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h3;
    phy_status     = '0;
    cycles(8);
    srst <= 1'b0;
    cycles(2);
    t_regs();
    t_default();
    t_on_conds();
    t_force();
    t_blink();
    t_activity();
    t_rate();
    t_hold(16'h0080, 6'b100100);
    t_hold(16'h0040, 6'b100010);
    tally_and_finish();
  end
endmodule
`default_nettype wire
